//--- include/bbm_pkg.sv
// Constants for the host-side NAND block management engine.
// Assumes a flash command/timing engine elsewhere does the pin cycles.
package bbm_pkg;
  localparam int unsigned NUM_BLOCKS = 2048;
  localparam int unsigned MIN_GOOD_BLOCKS = 2008;
  localparam int unsigned PAGES_PER_BLOCK = 64;
  localparam int unsigned ADDR_CYCLES = 5;
  localparam int unsigned MAX_PARTIAL = 4;
  localparam int unsigned ECC_CORR_BITS = 8;
  localparam int unsigned ECC_UNIT_BYTES = 512;
  localparam logic [7:0] BAD_MARK = 8'h00;
  localparam logic [7:0] PAD_BYTE = 8'hff;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam int unsigned ST_FAIL_BIT = 0;
  // Page buffer ready; pass/fail is only valid while this is set
  localparam int unsigned ST_READY_BIT = 5;
  localparam logic [3:0] REWRITE_THRESH = 4'h6;
  localparam logic [15:0] WEAR_RESET = 16'h0000;

  typedef enum logic [1:0] {
    OP_READ = 2'b00,
    OP_PROG = 2'b01,
    OP_ERASE = 2'b10,
    OP_SCAN = 2'b11
  } op_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_ISSUE = 3'b001,
    S_WAIT = 3'b010,
    S_STATUS = 3'b011,
    S_UPDATE = 3'b100,
    S_WEAR = 3'b101
  } state_t;
endpackage : bbm_pkg

//--- src/bbm_wear_pick.sv
// Sequential search for the least-erased good block.
// Assumes bad flags and wear counts are read one index per cycle.
`timescale 1ns/10ps
module bbm_wear_pick #(
  parameter int unsigned NB = 2048,
  parameter int unsigned AW = 11
) (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic start_i,
  input wire logic bad_i,
  input wire logic [15:0] wear_i,
  output logic [AW-1:0] idx_o,
  output logic busy_o,
  output logic found_o,
  output logic [AW-1:0] best_o
);
  logic [AW-1:0] idx_q, idx_d, best_q, best_d;
  logic [15:0] min_q, min_d;
  logic busy_q, busy_d, found_q, found_d;

  always_comb
  begin
    idx_d = idx_q;
    best_d = best_q;
    min_d = min_q;
    busy_d = busy_q;
    found_d = found_q;
    if (start_i && !busy_q)
    begin
      idx_d = '0;
      min_d = 16'hffff;
      busy_d = 1'b1;
      found_d = 1'b0;
    end
    else if (busy_q)
    begin
      if (!bad_i && (!found_q || wear_i < min_q))
      begin
        min_d = wear_i;
        best_d = idx_q;
        found_d = 1'b1;
      end
      if (idx_q == AW'(NB - 1))
        busy_d = 1'b0;
      else
        idx_d = idx_q + AW'(1);
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      idx_q <= '0;
      best_q <= '0;
      min_q <= 16'hffff;
      busy_q <= 1'b0;
      found_q <= 1'b0;
    end
    else if (ce_i)
    begin
      idx_q <= idx_d;
      best_q <= best_d;
      min_q <= min_d;
      busy_q <= busy_d;
      found_q <= found_d;
    end
  end

  assign idx_o = idx_q;
  assign busy_o = busy_q;
  assign found_o = found_q;
  assign best_o = best_q;
endmodule : bbm_wear_pick

//--- src/bbm_manager.sv
// Host block manager: vets requests, tracks bad blocks, wear, partials.
// Assumes a flash engine performs each op and returns the status byte.
`timescale 1ns/10ps
module bbm_manager #(
  parameter int unsigned NB = bbm_pkg::NUM_BLOCKS,
  parameter int unsigned NP = bbm_pkg::PAGES_PER_BLOCK,
  parameter int unsigned AW = 11,
  parameter int unsigned PW = 6
) (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  // User request
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic [1:0] req_op_i,
  input wire logic [AW-1:0] req_block_i,
  input wire logic [PW-1:0] req_page_i,
  output logic done_o,
  output logic refused_o,
  output logic failed_o,
  output logic replace_o,
  output logic [AW-1:0] replace_block_o,
  output logic [7:0] pad_byte_o,
  // Flash engine
  output logic fl_start_o,
  output logic [1:0] fl_op_o,
  output logic [AW-1:0] fl_block_o,
  output logic [PW-1:0] fl_page_o,
  output logic [2:0] fl_addr_cycles_o,
  output logic [7:0] fl_status_cmd_o,
  input wire logic fl_done_i,
  input wire logic [7:0] fl_data_i,
  input wire logic [7:0] fl_status_i,
  // ECC decoder, rewrite request and good-block count
  input wire logic ecc_valid_i,
  input wire logic [3:0] ecc_corrected_i,
  input wire logic ecc_uncorrectable_i,
  output logic rewrite_o,
  output logic [AW-1:0] rewrite_block_o,
  output logic [AW:0] good_count_o,
  output logic low_good_o
);
  // Arrays: bad flags, erase wear, partial count per page
  logic bad_q [NB];
  logic [15:0] wear_q [NB];
  logic [2:0] part_q [NB*NP];

  bbm_pkg::state_t st_q, st_d;
  logic [1:0] op_q, op_d;
  logic [AW-1:0] blk_q, blk_d;
  logic [PW-1:0] pg_q, pg_d;
  logic [7:0] stat_q, stat_d;
  logic [AW:0] good_q, good_d;
  logic done_q, done_d, ref_q, ref_d, fail_q, fail_d;
  logic rep_q, rep_d, rw_q, rw_d;
  logic [AW-1:0] rwb_q, rwb_d;
  logic mark_bad, wear_inc, part_inc, part_clr, pick_start;
  logic pick_busy, pick_found;
  logic [AW-1:0] pick_idx, pick_best;

  function automatic logic [AW+PW-1:0] pidx(input logic [AW-1:0] b,
                                           input logic [PW-1:0] p);
    pidx = {b, p};
  endfunction : pidx

  bbm_wear_pick #(.NB(NB), .AW(AW)) u_pick (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .start_i(pick_start),
    .bad_i(bad_q[pick_idx]),
    .wear_i(wear_q[pick_idx]),
    .idx_o(pick_idx),
    .busy_o(pick_busy),
    .found_o(pick_found),
    .best_o(pick_best)
  );

  always_comb
  begin
    st_d = st_q;
    op_d = op_q;
    blk_d = blk_q;
    pg_d = pg_q;
    stat_d = stat_q;
    good_d = good_q;
    done_d = 1'b0;
    ref_d = 1'b0;
    fail_d = 1'b0;
    rep_d = 1'b0;
    rw_d = 1'b0;
    rwb_d = rwb_q;
    mark_bad = 1'b0;
    wear_inc = 1'b0;
    part_inc = 1'b0;
    part_clr = 1'b0;
    pick_start = 1'b0;
    unique case (st_q)
      bbm_pkg::S_IDLE:
      begin
        if (req_valid_i)
        begin
          op_d = req_op_i;
          blk_d = req_block_i;
          pg_d = req_page_i;
          if (req_op_i != bbm_pkg::OP_SCAN && bad_q[req_block_i])
          begin
            ref_d = 1'b1;
            done_d = 1'b1;
          end
          else if (req_op_i == bbm_pkg::OP_PROG &&
                   part_q[pidx(req_block_i, req_page_i)] >=
                   3'(bbm_pkg::MAX_PARTIAL))
          begin
            ref_d = 1'b1;
            done_d = 1'b1;
          end
          else
            st_d = bbm_pkg::S_ISSUE;
        end
      end
      bbm_pkg::S_ISSUE:
        st_d = bbm_pkg::S_WAIT;
      bbm_pkg::S_WAIT:
      begin
        if (fl_done_i)
        begin
          stat_d = fl_status_i;
          if (op_q == bbm_pkg::OP_SCAN)
          begin
            if (fl_data_i == bbm_pkg::BAD_MARK && !bad_q[blk_q])
            begin
              mark_bad = 1'b1;
              good_d = good_q - (AW+1)'(1);
            end
            done_d = 1'b1;
            st_d = bbm_pkg::S_IDLE;
          end
          else if (op_q == bbm_pkg::OP_READ)
          begin
            done_d = 1'b1;
            st_d = bbm_pkg::S_IDLE;
          end
          else
            st_d = bbm_pkg::S_STATUS;
        end
      end
      bbm_pkg::S_STATUS:
      begin
        // Pass/fail only meaningful once ready bit is set
        if (stat_q[bbm_pkg::ST_READY_BIT])
          st_d = bbm_pkg::S_UPDATE;
        else
          st_d = bbm_pkg::S_WAIT;
      end
      bbm_pkg::S_UPDATE:
      begin
        if (op_q == bbm_pkg::OP_ERASE)
        begin
          wear_inc = 1'b1;
          part_clr = !stat_q[bbm_pkg::ST_FAIL_BIT];
        end
        else
          part_inc = 1'b1;
        if (stat_q[bbm_pkg::ST_FAIL_BIT])
        begin
          mark_bad = 1'b1;
          good_d = good_q - (AW+1)'(1);
          fail_d = 1'b1;
          if (op_q == bbm_pkg::OP_PROG)
          begin
            pick_start = 1'b1;
            st_d = bbm_pkg::S_WEAR;
          end
          else
          begin
            done_d = 1'b1;
            st_d = bbm_pkg::S_IDLE;
          end
        end
        else
        begin
          done_d = 1'b1;
          st_d = bbm_pkg::S_IDLE;
        end
      end
      bbm_pkg::S_WEAR:
      begin
        if (!pick_busy && !pick_start)
        begin
          rep_d = pick_found;
          done_d = 1'b1;
          st_d = bbm_pkg::S_IDLE;
        end
      end
      default:
        st_d = bbm_pkg::S_IDLE;
    endcase
    // ECC counts never mark a block bad, only ask for a rewrite
    if (ecc_valid_i && !ecc_uncorrectable_i &&
        ecc_corrected_i >= bbm_pkg::REWRITE_THRESH)
    begin
      rw_d = 1'b1;
      rwb_d = blk_q;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st_q <= bbm_pkg::S_IDLE;
      op_q <= bbm_pkg::OP_READ;
      blk_q <= '0;
      pg_q <= '0;
      stat_q <= 8'h00;
      good_q <= (AW+1)'(NB);
      done_q <= 1'b0;
      ref_q <= 1'b0;
      fail_q <= 1'b0;
      rep_q <= 1'b0;
      rw_q <= 1'b0;
      rwb_q <= '0;
    end
    else if (ce_i)
    begin
      st_q <= st_d;
      op_q <= op_d;
      blk_q <= blk_d;
      pg_q <= pg_d;
      stat_q <= stat_d;
      good_q <= good_d;
      done_q <= done_d;
      ref_q <= ref_d;
      fail_q <= fail_d;
      rep_q <= rep_d;
      rw_q <= rw_d;
      rwb_q <= rwb_d;
    end
  end

  // Tables kept without reset; cleared by an init pass is cheaper than
  // resetting 2048 block entries and 131072 page counts, so scan must run first after power-up.
  always_ff @(posedge mclk_i)
  begin
    if (ce_i)
    begin
      if (mark_bad)
        bad_q[blk_q] <= 1'b1;
      if (wear_inc)
        wear_q[blk_q] <= wear_q[blk_q] + 16'h0001;
      if (part_inc)
        part_q[pidx(blk_q, pg_q)] <= part_q[pidx(blk_q, pg_q)] + 3'h1;
      if (part_clr)
        for (int p = 0; p < NP; p++)
          part_q[pidx(blk_q, PW'(p))] <= 3'h0;
      if (st_q == bbm_pkg::S_ISSUE && op_q == bbm_pkg::OP_SCAN)
      begin
        bad_q[blk_q] <= 1'b0;
        wear_q[blk_q] <= bbm_pkg::WEAR_RESET;
        for (int p = 0; p < NP; p++)
          part_q[pidx(blk_q, PW'(p))] <= 3'h0;
      end
    end
  end

  assign req_ready_o = (st_q == bbm_pkg::S_IDLE);
  assign done_o = done_q;
  assign refused_o = ref_q;
  assign failed_o = fail_q;
  assign replace_o = rep_q;
  assign replace_block_o = pick_best;
  assign pad_byte_o = bbm_pkg::PAD_BYTE;
  assign fl_start_o = (st_q == bbm_pkg::S_ISSUE) ||
                      (st_q == bbm_pkg::S_STATUS &&
                       !stat_q[bbm_pkg::ST_READY_BIT]);
  assign fl_op_o = op_q;
  assign fl_block_o = blk_q;
  assign fl_page_o = pg_q;
  assign fl_addr_cycles_o = 3'(bbm_pkg::ADDR_CYCLES);
  assign fl_status_cmd_o = bbm_pkg::CMD_STATUS;
  assign rewrite_o = rw_q;
  assign rewrite_block_o = rwb_q;
  assign good_count_o = good_q;
  assign low_good_o = good_q < (AW+1)'(bbm_pkg::MIN_GOOD_BLOCKS);
endmodule : bbm_manager

//--- bench/bbm_flash_model.sv
// Behavioural flash engine answering the block manager's start pulses.
// Assumes a single die; blocks 5 and 9 carry the factory bad mark.
`timescale 1ns/10ps
module bbm_flash_model (
  input wire logic mclk_i,
  input wire logic start_i,
  input wire logic [1:0] op_i,
  input wire logic [10:0] block_i,
  input wire logic fail_i,
  input wire logic slow_i,
  output logic done_o = 1'b0,
  output logic [7:0] data_o = 8'h00,
  output logic [7:0] status_o = 8'h00
);
  logic [2:0] cnt_q = 3'h0;
  logic busy_q = 1'b0;
  logic polled_q = 1'b0;
  always_ff @(posedge mclk_i)
  begin
    done_o <= 1'b0;
    if (start_i)
    begin
      busy_q <= 1'b1;
      cnt_q <= slow_i ? 3'h6 : 3'h2;
    end
    else if (busy_q)
    begin
      cnt_q <= cnt_q - 3'h1;
      if (cnt_q == 3'h1)
      begin
        busy_q <= 1'b0;
        done_o <= 1'b1;
        // Address taken from block only; extra cycles change nothing
        data_o <= (block_i == 11'h5 || block_i == 11'h9) ?
                  8'h00 : 8'h5a;
        // First answer of a slow op reports busy on both ready bits
        status_o <= {1'b1, {2{!slow_i || polled_q}}, 4'h0,
                     fail_i && op_i != 2'b00};
        polled_q <= slow_i && !polled_q;
      end
    end
    // Released bus no longer shows the last value
    if (done_o)
    begin
      data_o <= ~data_o;
      status_o <= ~status_o;
    end
  end
endmodule : bbm_flash_model

//--- bench/bbm_manager_assertions.sv
// Port-level checks on the block manager.
// Assumes a single clock domain with async active-low reset.
`timescale 1ns/10ps
module bbm_checker #(
  parameter int unsigned AW = 11
) (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic req_ready_o,
  input wire logic done_o,
  input wire logic refused_o,
  input wire logic failed_o,
  input wire logic replace_o,
  input wire logic [AW-1:0] replace_block_o,
  input wire logic [7:0] pad_byte_o,
  input wire logic fl_start_o,
  input wire logic [AW-1:0] fl_block_o,
  input wire logic [2:0] fl_addr_cycles_o,
  input wire logic [7:0] fl_status_cmd_o,
  input wire logic fl_done_i,
  input wire logic [7:0] fl_status_i,
  input wire logic rewrite_o,
  input wire logic [AW-1:0] rewrite_block_o,
  input wire logic [AW:0] good_count_o,
  input wire logic low_good_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  a_refuse_with_done: assert property (refused_o |-> done_o)
    else $error("refusal without done");
  a_fail_not_refused: assert property (failed_o |-> !refused_o)
    else $error("fail and refusal together");
  a_replace_differs: assert property (
    replace_o |-> replace_block_o != fl_block_o)
    else $error("replacement equals failed block");
  a_five_addr: assert property (fl_addr_cycles_o == 3'h5)
    else $error("address cycle count wrong");
  a_pad_ones: assert property (pad_byte_o == 8'hff)
    else $error("pad byte not all ones");
  a_status_cmd: assert property (fl_status_cmd_o == 8'h70)
    else $error("status command wrong");
  a_low_good_flag: assert property (
    low_good_o == (good_count_o < 2008))
    else $error("low good flag wrong");
  a_pass_done: assert property (
    fl_done_i && fl_status_i[5] && !fl_status_i[0] |-> ##[1:3] done_o)
    else $error("no done after passing status");
  a_rewrite_block: assert property (
    rewrite_o |-> rewrite_block_o == fl_block_o)
    else $error("rewrite block wrong");
  a_start_busy: assert property (fl_start_o |-> !req_ready_o)
    else $error("ready while engine started");
  c_refused: cover property (refused_o);
  c_failed: cover property (failed_o);
  c_replace: cover property (replace_o);
  c_rewrite: cover property (rewrite_o);
endmodule : bbm_checker

bind bbm_manager bbm_checker #(.AW(AW)) chk_i (.mclk_i, .arst_n_i,
  .req_ready_o, .done_o, .refused_o, .failed_o, .replace_o,
  .replace_block_o, .pad_byte_o, .fl_start_o, .fl_block_o,
  .fl_addr_cycles_o, .fl_status_cmd_o, .fl_done_i, .fl_status_i,
  .rewrite_o, .rewrite_block_o, .good_count_o, .low_good_o);

//--- bench/nand_bad_block_management_test.sv
// Self-checking bench for the block manager with a flash engine model.
// Assumes blocks 5 and 9 are factory bad in the model.
`timescale 1ns/10ps
module nand_bad_block_management_test;
  logic mclk_i = 0, arst_n_i = 0, ce_i = 0, req_valid_i = 0;
  logic [1:0] req_op_i = 0;
  logic [10:0] req_block_i = 0;
  logic [5:0] req_page_i = 0;
  logic ecc_valid_i = 0, ecc_uncorrectable_i = 0;
  logic [3:0] ecc_corrected_i = 0;
  logic req_ready_o, done_o, refused_o, failed_o, replace_o, fl_start_o;
  logic fl_done_i, rewrite_o, low_good_o;
  logic [10:0] replace_block_o, fl_block_o, rewrite_block_o;
  logic [7:0] pad_byte_o, fl_status_cmd_o, fl_data_i, fl_status_i;
  logic [1:0] fl_op_o;
  logic [5:0] fl_page_o;
  logic [2:0] fl_addr_cycles_o;
  logic [11:0] good_count_o;
  logic fail_q = 0, slow_q = 0, r_ref, r_fail, r_rep, r_rw;
  logic [10:0] r_blk;
  int fail_count = 0, tests_run = 0, cyc = 0;
  always #5 mclk_i = ~mclk_i;
  bbm_manager dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
    .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
    .req_op_i(req_op_i), .req_block_i(req_block_i),
    .req_page_i(req_page_i), .done_o(done_o), .refused_o(refused_o),
    .failed_o(failed_o), .replace_o(replace_o),
    .replace_block_o(replace_block_o), .pad_byte_o(pad_byte_o),
    .fl_start_o(fl_start_o), .fl_op_o(fl_op_o), .fl_block_o(fl_block_o),
    .fl_page_o(fl_page_o), .fl_addr_cycles_o(fl_addr_cycles_o),
    .fl_status_cmd_o(fl_status_cmd_o), .fl_done_i(fl_done_i),
    .fl_data_i(fl_data_i), .fl_status_i(fl_status_i),
    .ecc_valid_i(ecc_valid_i), .ecc_corrected_i(ecc_corrected_i),
    .ecc_uncorrectable_i(ecc_uncorrectable_i), .rewrite_o(rewrite_o),
    .rewrite_block_o(rewrite_block_o), .good_count_o(good_count_o),
    .low_good_o(low_good_o));
  bbm_flash_model fm (.mclk_i, .start_i(fl_start_o), .op_i(fl_op_o),
    .block_i(fl_block_o), .fail_i(fail_q), .slow_i(slow_q),
    .done_o(fl_done_i), .data_o(fl_data_i), .status_o(fl_status_i));
  task chk(input string n, input logic [11:0] e, input logic [11:0] s);
    tests_run++;
    if (s !== e)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task close_out;
    if (fail_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  task req(input logic [1:0] op, input logic [10:0] b,
           input logic [5:0] p, input logic ecc);
    {r_ref, r_fail, r_rep, r_rw} = 4'h0;
    @(posedge mclk_i);
    {req_op_i, req_block_i, req_page_i, req_valid_i} <= {op, b, p, 1'b1};
    @(posedge mclk_i);
    req_valid_i <= 1'b0;
    // Refusals answer at the take edge, so look before the next edge
    repeat (3000)
    begin
      #1;
      {r_ref, r_fail} = {r_ref | refused_o, r_fail | failed_o};
      {r_rep, r_rw} = {r_rep | replace_o, r_rw | rewrite_o};
      if (replace_o) r_blk = replace_block_o;
      if (done_o) break;
      @(posedge mclk_i);
      ecc_valid_i <= ecc && fl_done_i;
    end
    // Rewrite request trails the ECC pulse by one cycle
    @(posedge mclk_i);
    ecc_valid_i <= 1'b0;
    #1;
    r_rw = r_rw | rewrite_o;
  endtask : req
  task t_scan;
    for (int b = 0; b < 2048; b++) req(2'h3, 11'(b), 6'h0, 0);
    chk("good count", 12'd2046, good_count_o);
    chk("low good", 12'h0, low_good_o);
  endtask : t_scan
  task t_bad;
    req(2'h0, 11'h5, 6'h0, 0);
    chk("read bad", 1, r_ref);
    chk("ready after refusal", 12'h1, req_ready_o);
    req(2'h2, 11'h9, 6'h0, 0);
    chk("erase bad", 1, r_ref);
  endtask : t_bad
  task t_partial;
    repeat (4)
    begin
      req(2'h1, 11'h1, 6'h3, 0);
      chk("partial ok", 0, r_ref);
      chk("engine op", 12'h1, fl_op_o);
      chk("engine page", 12'h3, fl_page_o);
    end
    req(2'h1, 11'h1, 6'h3, 0);
    chk("fifth partial", 1, r_ref);
    req(2'h2, 11'h1, 6'h0, 0);
    req(2'h1, 11'h1, 6'h3, 0);
    chk("after erase", 0, r_ref);
  endtask : t_partial
  task t_erase_fail;
    fail_q = 1;
    req(2'h2, 11'h2, 6'h0, 0);
    fail_q = 0;
    chk("erase failed", 1, r_fail);
    chk("good count", 12'd2045, good_count_o);
    req(2'h0, 11'h2, 6'h0, 0);
    chk("read failed blk", 1, r_ref);
  endtask : t_erase_fail
  task t_prog_fail;
    {fail_q, slow_q} = 2'b11;
    req(2'h1, 11'h3, 6'h0, 0);
    {fail_q, slow_q} = 2'b00;
    chk("prog failed", 1, r_fail);
    chk("replace", 1, r_rep);
    chk("pick good", 0, 12'(r_blk inside {2, 3, 5, 9}));
    chk("least worn", 12'h0, r_blk);
    req(2'h1, r_blk, 6'h0, 0);
    chk("resend", 0, r_ref);
    req(2'h1, 11'h3, 6'h1, 0);
    chk("prog failed blk", 1, r_ref);
  endtask : t_prog_fail
  task t_ecc;
    @(posedge mclk_i) ecc_corrected_i <= 4'h6;
    req(2'h0, 11'h4, 6'h0, 1);
    chk("rewrite", 1, r_rw);
    chk("rewrite block", 12'h4, rewrite_block_o);
    @(posedge mclk_i) ecc_corrected_i <= 4'h5;
    req(2'h0, 11'h4, 6'h0, 1);
    chk("no rewrite", 0, r_rw);
    @(posedge mclk_i) {ecc_corrected_i, ecc_uncorrectable_i} <= 5'h0d;
    req(2'h0, 11'h4, 6'h0, 1);
    chk("uncorrectable rewrite", 0, r_rw);
    @(posedge mclk_i) ecc_uncorrectable_i <= 1'b0;
    req(2'h1, 11'h4, 6'h0, 0);
    chk("still usable", 0, r_ref);
    chk("good count", 12'd2044, good_count_o);
  endtask : t_ecc
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      fail_count++;
      close_out;
    end
  end
  initial
  begin
    repeat (20) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    ce_i <= 1'b1;
    t_scan;
    t_bad;
    t_partial;
    t_erase_fail;
    t_prog_fail;
    t_ecc;
    close_out;
  end
endmodule : nand_bad_block_management_test
